// File: opmode_regs.svh
// Purpose: Field positions, mode codes and timing counts of the
//          operating mode register.
// Assumes: 8-bit register, mode code in bits 7:5.
// Notes:   Definitions only.
`ifndef OPMODE_REGS_SVH
`define OPMODE_REGS_SVH

`define OPM_MODE_MSB        7
`define OPM_MODE_LSB        5
`define OPM_VIS_BIT         3
`define OPM_EMUL_K_BIT      1
`define OPM_EMUL_E_BIT      0

`define OPM_SPECIAL_SINGLE  3'h0
`define OPM_EMUL_NARROW     3'h1
`define OPM_SPECIAL_TEST    3'h2
`define OPM_EMUL_WIDE       3'h3
`define OPM_NORMAL_SINGLE   3'h4
`define OPM_NORMAL_NARROW   3'h5
`define OPM_PERIPHERAL      3'h6
`define OPM_NORMAL_WIDE     3'h7

`define OPM_RESET_VALUE     8'h00
`define OPM_STRAP_SETTLE    2'h2

`endif

// File: opmode_pkg.sv
// Purpose: Types shared by the operating mode register files.
// Assumes: Constants come from opmode_regs.svh.
// Notes:   Types only.
package opmode_pkg;

    typedef logic [2:0] mode_code_t;

    typedef enum logic [1:0] {
        BOOT_SETTLE,
        BOOT_LOAD,
        BOOT_RUN
    } boot_state_t;

    typedef struct packed {
        logic [2:0]  strap_meta;
        logic [2:0]  strap_sync;
        logic [1:0]  settle_cnt;
        boot_state_t boot;
        mode_code_t  mode;
        logic        vis;
        logic        emul_k;
        logic        emul_e;
        logic        mode_lock;
        logic        vis_lock;
        logic        emul_k_lock;
        logic [7:0]  rdata;
    } opmode_state_t;

endpackage

// File: mode_write_policy.sv
// Purpose: Decides which fields of one register write are accepted.
// Assumes: Current mode and lock flags come from the register owner.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`include "opmode_regs.svh"

module mode_write_policy (
    input  wire logic                  wr_stb,
    input  wire logic [7:0]            wdata,
    input  wire opmode_pkg::mode_code_t mode,
    input  wire logic                  mode_lock,
    input  wire logic                  vis_lock,
    input  wire logic                  emul_k_lock,
    output logic                       mode_we,
    output opmode_pkg::mode_code_t     mode_new,
    output logic                       vis_we,
    output logic                       emul_k_we,
    output logic                       emul_e_we,
    output logic                       mode_lock_set,
    output logic                       vis_lock_set,
    output logic                       emul_k_lock_set
);

    function automatic logic is_special(input opmode_pkg::mode_code_t m);
        is_special = (m[2] == 1'b0) && (m[0] == 1'b0);
    endfunction

    function automatic logic is_normal(input opmode_pkg::mode_code_t m);
        is_normal = (m[2] == 1'b1) && (m != `OPM_PERIPHERAL);
    endfunction

    opmode_pkg::mode_code_t req;
    logic                   special_m;
    logic                   normal_m;

    always_comb begin
        req       = wdata[`OPM_MODE_MSB:`OPM_MODE_LSB];
        special_m = is_special(mode);
        normal_m  = is_normal(mode);
        mode_we       = 1'b0;
        mode_new      = mode;
        mode_lock_set = 1'b0;
        if (wr_stb && mode[0] == 1'b0 && mode != `OPM_PERIPHERAL) begin
            if (special_m) begin
                if (req != `OPM_PERIPHERAL) begin
                    mode_we  = 1'b1;
                    mode_new = req;
                end
            end else if (mode == `OPM_NORMAL_SINGLE && !mode_lock) begin
                // Top bit kept; only the expanded targets get through
                mode_lock_set = 1'b1;
                if (req[0] == 1'b1) begin
                    mode_we  = 1'b1;
                    mode_new = {1'b1, req[1:0]};
                end
            end
        end
        vis_we       = wr_stb && (special_m || (normal_m && !vis_lock));
        vis_lock_set = wr_stb && normal_m;
        emul_k_we       = wr_stb && (special_m ||
                                     (normal_m && !emul_k_lock));
        emul_k_lock_set = wr_stb && normal_m;
        emul_e_we       = wr_stb && special_m;
    end

endmodule

// File: operating_mode_register.sv
// Contract
// - Bits 7:5 hold the operating mode code.
// - Lowest mode bit set blocks mode writes.
// - Special modes rewrite mode freely, never peripheral.
// - Normal single chip: one write, expanded only.
// - Peripheral mode permits no mode writes.
// - Written changes appear one cycle after write.
// - Reset value follows the strapped mode.
// - Unmapped in expanded/peripheral; accesses echo externally.
// - Bit 3 drives internal visibility, mode-gated writes.
// - Bit 1 unmaps port K in expanded modes.
// - Port K mapped single chip, never peripheral.
// - Bit 0 unmaps port E; special-only writes.
// - Port E always mapped in single chip.
// - Special to normal single leaves one write.
//
// Purpose: Operating mode register with write gating and map steering.
// Assumes: mode_pins are static straps, sampled after reset release.
// Notes:   Accesses before cfg_ready are ignored.
`timescale 1ns/1ps
`include "opmode_regs.svh"

module operating_mode_register (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic [2:0] mode_pins,
    input  wire logic       acc_sel,
    input  wire logic       acc_wr,
    input  wire logic [7:0] acc_wdata,
    output logic [7:0]      acc_rdata,
    output logic            acc_echo,
    output logic            cfg_ready,
    output logic [2:0]      mode_sel,
    output logic            internal_visibility,
    output logic            emulate_port_k,
    output logic            emulate_port_e,
    output logic            reg_mapped,
    output logic            port_k_regs_mapped,
    output logic            port_e_regs_mapped
);

    opmode_pkg::opmode_state_t st_reg;
    opmode_pkg::opmode_state_t st_next;

    logic                   running;
    logic                   single_chip;
    logic                   expanded;
    logic                   peripheral;
    logic                   wr_stb;
    logic                   rd_stb;
    logic                   mode_we;
    opmode_pkg::mode_code_t mode_new;
    logic                   vis_we;
    logic                   emul_k_we;
    logic                   emul_e_we;
    logic                   mode_lock_set;
    logic                   vis_lock_set;
    logic                   emul_k_lock_set;

    function automatic logic is_emulation(input opmode_pkg::mode_code_t m);
        is_emulation = (m[2] == 1'b0) && (m[0] == 1'b1);
    endfunction

    assign running     = (st_reg.boot == opmode_pkg::BOOT_RUN);
    assign single_chip = (st_reg.mode == `OPM_SPECIAL_SINGLE) ||
                         (st_reg.mode == `OPM_NORMAL_SINGLE);
    assign expanded    = st_reg.mode[0];
    assign peripheral  = (st_reg.mode == `OPM_PERIPHERAL);

    // Register drops out of the map; the access goes to the pins
    assign reg_mapped = running && !expanded && !peripheral;
    assign acc_echo   = acc_sel && running && !reg_mapped;
    assign wr_stb     = acc_sel && acc_wr && reg_mapped;
    assign rd_stb     = acc_sel && !acc_wr && reg_mapped;

    mode_write_policy u_policy (
        .wr_stb          (wr_stb),
        .wdata           (acc_wdata),
        .mode            (st_reg.mode),
        .mode_lock       (st_reg.mode_lock),
        .vis_lock        (st_reg.vis_lock),
        .emul_k_lock     (st_reg.emul_k_lock),
        .mode_we         (mode_we),
        .mode_new        (mode_new),
        .vis_we          (vis_we),
        .emul_k_we       (emul_k_we),
        .emul_e_we       (emul_e_we),
        .mode_lock_set   (mode_lock_set),
        .vis_lock_set    (vis_lock_set),
        .emul_k_lock_set (emul_k_lock_set)
    );

    always_comb begin
        st_next            = st_reg;
        st_next.strap_meta = mode_pins;
        st_next.strap_sync = st_reg.strap_meta;
        case (st_reg.boot)
            opmode_pkg::BOOT_SETTLE: begin
                // Straps pass the synchroniser before anything uses them
                if (st_reg.settle_cnt == `OPM_STRAP_SETTLE) begin
                    st_next.boot = opmode_pkg::BOOT_LOAD;
                end else begin
                    st_next.settle_cnt = st_reg.settle_cnt + 2'h1;
                end
            end
            opmode_pkg::BOOT_LOAD: begin
                st_next.mode = st_reg.strap_sync;
                st_next.vis  = is_emulation(st_reg.strap_sync) ||
                    (st_reg.strap_sync == `OPM_SPECIAL_TEST);
                st_next.emul_k = is_emulation(st_reg.strap_sync);
                st_next.emul_e = is_emulation(st_reg.strap_sync);
                st_next.boot = opmode_pkg::BOOT_RUN;
            end
            opmode_pkg::BOOT_RUN: begin
                // All fields update on the write edge, seen next cycle
                if (mode_we) begin
                    st_next.mode = mode_new;
                end
                if (vis_we) begin
                    st_next.vis = acc_wdata[`OPM_VIS_BIT];
                end
                if (emul_k_we) begin
                    st_next.emul_k = acc_wdata[`OPM_EMUL_K_BIT];
                end
                if (emul_e_we) begin
                    st_next.emul_e = acc_wdata[`OPM_EMUL_E_BIT];
                end
                // Locks are only ever set; reset is the sole release
                st_next.mode_lock = st_reg.mode_lock | mode_lock_set;
                st_next.vis_lock  = st_reg.vis_lock | vis_lock_set;
                st_next.emul_k_lock = st_reg.emul_k_lock |
                                      emul_k_lock_set;
                if (rd_stb) begin
                    st_next.rdata = {st_reg.mode, 1'b0, st_reg.vis,
                                     1'b0, st_reg.emul_k,
                                     st_reg.emul_e};
                end
            end
            default: begin
                st_next.boot = opmode_pkg::BOOT_SETTLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '{strap_meta: 3'h0,
                        strap_sync: 3'h0,
                        settle_cnt: 2'h0,
                        boot:       opmode_pkg::BOOT_SETTLE,
                        mode:       3'h0,
                        vis:        1'b0,
                        emul_k:     1'b0,
                        emul_e:     1'b0,
                        mode_lock:  1'b0,
                        vis_lock:   1'b0,
                        emul_k_lock: 1'b0,
                        rdata:      `OPM_RESET_VALUE};
        end else begin
            st_reg <= st_next;
        end
    end

    assign acc_rdata           = st_reg.rdata;
    assign cfg_ready           = running;
    assign mode_sel            = st_reg.mode;
    assign internal_visibility = st_reg.vis;
    assign emulate_port_k      = st_reg.emul_k;
    assign emulate_port_e      = st_reg.emul_e;

    // Port K: fixed in single chip, special test and peripheral, bit 1 in expanded modes
    assign port_k_regs_mapped = running && !peripheral &&
        (single_chip || !(expanded && st_reg.emul_k));
    // Port E: single chip and special test always mapped, bit 0 in expanded and peripheral
    assign port_e_regs_mapped = running &&
        (single_chip ||
         !((expanded || peripheral) && st_reg.emul_e));

endmodule

// File: operating_mode_register_sva.sv
// Purpose: Port-level checks of the operating mode register.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound to every instance of the register.
`timescale 1ns/1ps
module operating_mode_register_sva (
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire logic [2:0] mode_pins,
    input wire logic       acc_sel,
    input wire logic       acc_wr,
    input wire logic [7:0] acc_wdata,
    input wire logic [7:0] acc_rdata,
    input wire logic       acc_echo,
    input wire logic       cfg_ready,
    input wire logic [2:0] mode_sel,
    input wire logic       internal_visibility,
    input wire logic       emulate_port_k,
    input wire logic       emulate_port_e,
    input wire logic       reg_mapped,
    input wire logic       port_k_regs_mapped,
    input wire logic       port_e_regs_mapped
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic [7:0] img;
    logic       wr_ok;
    assign img = {mode_sel, 1'b0, internal_visibility, 1'b0,
                  emulate_port_k, emulate_port_e};
    assign wr_ok = acc_sel && acc_wr && reg_mapped;
    AST_ECHO: assert property (
        acc_echo == (acc_sel && cfg_ready && !reg_mapped))
        else $error("echo wrong");
    AST_MAP: assert property (
        reg_mapped == (cfg_ready && !mode_sel[0] && mode_sel != 3'h6))
        else $error("register mapping wrong");
    AST_PORT_K: assert property (
        port_k_regs_mapped == (cfg_ready && mode_sel != 3'h6
            && !(mode_sel[0] && emulate_port_k))) else $error("port k map");
    AST_PORT_E: assert property (
        port_e_regs_mapped == (cfg_ready && !((mode_sel[0]
            || mode_sel == 3'h6) && emulate_port_e))) else $error("port e map");
    AST_FROZEN: assert property (
        cfg_ready && (mode_sel[0] || mode_sel == 3'h6) |=> $stable(img))
        else $error("write-never mode changed");
    AST_NO_PERIPH: assert property (
        cfg_ready && mode_sel != 3'h6 |=> mode_sel != 3'h6)
        else $error("peripheral mode entered");
    AST_SPECIAL_WR: assert property (
        wr_ok && !mode_sel[2] && acc_wdata[7:5] != 3'h6
        |=> mode_sel == $past(acc_wdata[7:5])) else $error("mode write lost");
    AST_IDLE: assert property (
        cfg_ready && !wr_ok |=> $stable(img)) else $error("change w/o write");
    AST_LOAD: assert property (
        $rose(cfg_ready) |-> mode_sel == mode_pins && emulate_port_e
        == (mode_pins[0] && !mode_pins[2])) else $error("bad reset load");
endmodule
bind operating_mode_register operating_mode_register_sva u_sva (
    .ref_clk, .rst_b, .mode_pins, .acc_sel, .acc_wr, .acc_wdata, .acc_rdata,
    .acc_echo, .cfg_ready, .mode_sel, .internal_visibility, .emulate_port_k,
    .emulate_port_e, .reg_mapped, .port_k_regs_mapped, .port_e_regs_mapped);

// File: operating_mode_register_tb.sv
// Purpose: Self-checking bench of the operating mode register.
// Assumes: Straps change only while reset is held.
// Notes:   Straps are fixed per boot, so each scenario reboots.
`timescale 1ns/1ps
module operating_mode_register_tb;
    logic       ref_clk, rst_b, acc_sel, acc_wr, acc_echo, cfg_ready;
    logic       internal_visibility, emulate_port_k, emulate_port_e;
    logic       reg_mapped, port_k_regs_mapped, port_e_regs_mapped, echo_seen;
    logic [2:0] mode_pins, mode_sel;
    logic [7:0] acc_wdata, acc_rdata, e;
    int         n_mismatch = 0;
    int         check_count = 0;
    int         cycles = 0;
    operating_mode_register u_operating_mode_register (
        .ref_clk, .rst_b, .mode_pins, .acc_sel, .acc_wr, .acc_wdata,
        .acc_rdata, .acc_echo, .cfg_ready, .mode_sel, .internal_visibility,
        .emulate_port_k, .emulate_port_e, .reg_mapped, .port_k_regs_mapped,
        .port_e_regs_mapped);
    initial begin
        ref_clk = 0;
        forever #25 ref_clk = ~ref_clk;
    end
    // Whole run needs well under 300 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] img();
        return {mode_sel, 1'b0, internal_visibility, 1'b0,
                emulate_port_k, emulate_port_e};
    endfunction
    function automatic logic [7:0] maps();
        return {5'h00, reg_mapped, port_k_regs_mapped, port_e_regs_mapped};
    endfunction
    task automatic boot(input logic [2:0] m);
        @(posedge ref_clk) #1;
        rst_b = 0;
        mode_pins = m;
        repeat (2) @(posedge ref_clk);
        chk(maps() | {6'h00, acc_echo, cfg_ready}, 8'h00);
        #1 rst_b = 1;
        // Bounded wait, load takes four edges
        for (int i = 0; i < 12 && cfg_ready !== 1'b1; i++)
            @(posedge ref_clk) #1;
        chk({7'h00, cfg_ready}, 8'h01);
    endtask
    task automatic acc(input logic w, input logic [7:0] d);
        @(posedge ref_clk) #1;
        acc_sel = 1;
        acc_wr = w;
        acc_wdata = d;
        #1 echo_seen = acc_echo;
        @(posedge ref_clk) #1;
        acc_sel = 0;
    endtask
    task automatic t_reset;
        for (int i = 0; i < 8; i++) begin
            boot(i[2:0]);
            e = {i[2:0], 1'b0, i != 0 && !i[2], 1'b0, {2{i[0] && !i[2]}}};
            chk(img(), e);
            chk(maps(), {5'h00, !i[0] && i != 6, i != 6 && !(i[0] && e[1]),
                !((i[0] || i == 6) && e[0])});
            if (i[0] || i == 6) begin
                acc(1'b1, 8'h4B);
                chk({7'h00, echo_seen}, 8'h01);
                chk(img(), e);
            end else begin
                acc(1'b0, 8'h00);
                chk({7'h00, echo_seen}, 8'h00);
                chk(acc_rdata, e);
            end
        end
    endtask
    task automatic t_special;
        boot(3'h0);
        acc(1'b1, 8'h5F);
        chk(img(), 8'h4B);
        chk(maps(), 8'h07);
        acc(1'b0, 8'h00);
        chk(acc_rdata, 8'h4B);
        acc(1'b1, 8'hDF);
        chk(img(), 8'h4B);
        acc(1'b1, 8'h80);
        chk(img(), 8'h80);
        acc(1'b1, 8'hAB);
        chk(img(), 8'hAA);
        chk(maps(), 8'h01);
        boot(3'h0);
        acc(1'b1, 8'h6B);
        chk(img(), 8'h6B);
        chk(maps(), 8'h00);
    endtask
    task automatic t_normal;
        boot(3'h4);
        acc(1'b1, 8'hCB);
        chk(img(), 8'h8A);
        acc(1'b1, 8'hA0);
        chk(img(), 8'h8A);
        chk(maps(), 8'h07);
        boot(3'h4);
        acc(1'b1, 8'h20);
        chk(img(), 8'hA0);
        chk(maps(), 8'h03);
    endtask
    initial begin
        rst_b = 0;
        acc_sel = 0;
        acc_wr = 0;
        acc_wdata = 8'h00;
        mode_pins = 3'h0;
        t_reset();
        t_special();
        t_normal();
        end_of_test();
    end
endmodule
